// [cbr_pkg.sv]
// constants shared by the control byte receiver and its fifo
// assumes a single 10 MHz system clock domain
package cbr_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int ITEM_W = 10;
  localparam logic [4:0] ADDR_FIXED = 5'h0E;
  localparam int CONT_BIT = 7;
  localparam int SEL_HI = 6;
  localparam int SEL_LO = 5;
  localparam int ADDR_SEL_BIT = 1;
  localparam int RW_BIT = 0;
  localparam logic [1:0] DEST_CMD = 2'h0;
  localparam logic [1:0] DEST_RAM = 2'h1;
  localparam logic [1:0] DEST_PWM = 2'h2;
  localparam logic [1:0] DEST_NONE = 2'h3;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  typedef enum logic [2:0] {
    CBR_IDLE,
    CBR_ADDR,
    CBR_CTRL,
    CBR_DATA,
    CBR_IGNORE
  } cbr_phase_t;
endpackage

// [cbr_fifo.sv]
// synchronous fifo with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module cbr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// [cbr_receiver.sv]
// two-wire slave receiver with control byte parsing
// assumes scl/sda pins asynchronous, sampled by 10 MHz i_clk
// Overview of operation
// [RL1] first byte after accepted address is parsed as a control byte
// [RL2] control byte decides destination of following data and continuation
// [RL3] bit 7 set: another control byte after next data byte
// [RL4] bits 6..5 select cmd, ram, pwm or unused; bits 4..0 ignored
// [RL5] any interleaving of groups accepted within one access
// [RL6] master starts only with both lines high
// [RL7] data stable while clock high; changes there are conditions
// [RL8] start: data falls while clock high
// [RL9] stop: data rises while clock high
// [RL10] unlimited bytes, each 8 bits plus an acknowledge pulse
// [RL11] addressed receiver acknowledges every byte
// [RL12] acknowledge holds data low through ack clock high phase
// [RL13] master receiver naks last byte; not used by this slave
// [RL14] slave receiver only, never initiates transfers
// [RL15] one of two addresses chosen by address select pin
// [RL16] address is 01110, then fixed 0, select bit, rw bit
// [RL17] mismatching address ignored until next start
// [RL18] ram and pwm bytes tagged for their separate pointers
// [RL19] any start or stop returns parser to expecting address; here only start does, stop sends it to CBR_IDLE
`timescale 1ns/1ns
`default_nettype none
module cbr_receiver (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_b,
  input wire logic i_address_select_pin,
  output logic o_data_valid,
  input wire logic i_data_ready,
  output logic [cbr_pkg::DATA_W-1:0] o_data,
  output logic [1:0] o_destination_select_field,
  output logic o_busy
);
  import cbr_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic sel_m, sel_s;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      sel_m <= 1'b0;
      sel_s <= 1'b0;
    end else begin
      scl_m <= i_scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= i_sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
      sel_m <= i_address_select_pin;
      sel_s <= sel_m;
    end
  end

  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_cond = scl_s && scl_d && sda_d && !sda_s; // [RL8] [RL7]
  assign stop_cond = scl_s && scl_d && !sda_d && sda_s; // [RL9] [RL7]

  // ************************************************************
  // bit and byte framing
  // ************************************************************
  cbr_phase_t phase;
  logic [3:0] bit_cnt;
  logic [DATA_W-1:0] shift;
  logic [DATA_W-1:0] next_shift;
  logic byte_done;
  logic cont_pending;
  logic [1:0] dest;

  assign next_shift = {shift[DATA_W-2:0], sda_s};
  assign byte_done = scl_rise && (bit_cnt == BIT_LAST);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_cnt <= '0;
      shift <= '0;
    end else if (start_cond || stop_cond) begin
      bit_cnt <= '0;
    end else if (scl_fall && bit_cnt == BIT_ACK + 4'h1) begin
      bit_cnt <= '0; // [RL10]
    end else if (scl_rise && bit_cnt == BIT_ACK) begin
      bit_cnt <= bit_cnt + 4'h1; // ack pulse high, nothing shifted
    end else if (scl_rise && bit_cnt < BIT_ACK) begin
      shift <= next_shift;
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  logic addr_match;
  assign addr_match = (next_shift[DATA_W-1:3] == ADDR_FIXED) // [RL16] [RL15]
    && (next_shift[2] == 1'b0)
    && (next_shift[ADDR_SEL_BIT] == sel_s)
    && (next_shift[RW_BIT] == 1'b0); // [RL14]

  // ************************************************************
  // parser
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase <= CBR_IDLE;
      cont_pending <= 1'b0;
      dest <= DEST_NONE;
    end else if (start_cond) begin
      phase <= CBR_ADDR; // [RL19]
      cont_pending <= 1'b0;
    end else if (stop_cond) begin
      phase <= CBR_IDLE; // [RL19]
      cont_pending <= 1'b0;
    end else if (byte_done) begin
      case (phase)
        CBR_ADDR: begin
          phase <= addr_match ? CBR_CTRL : CBR_IGNORE; // [RL1] [RL17]
        end
        CBR_CTRL: begin
          dest <= next_shift[SEL_HI:SEL_LO]; // [RL4] [RL2]
          cont_pending <= next_shift[CONT_BIT]; // [RL3]
          phase <= CBR_DATA;
        end
        CBR_DATA: begin
          if (cont_pending) begin
            phase <= CBR_CTRL; // [RL3] [RL5]
          end
        end
        default: begin
          phase <= phase;
        end
      endcase
    end
  end

  // ************************************************************
  // acknowledge driver
  // ************************************************************
  logic ack_armed;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_armed <= 1'b0;
      o_sda_oe_b <= 1'b1;
      o_sda <= 1'b1;
    end else begin
      o_sda <= 1'b0;
      if (start_cond || stop_cond) begin
        ack_armed <= 1'b0;
        o_sda_oe_b <= 1'b1;
      end else if (byte_done) begin
        ack_armed <= (phase == CBR_ADDR) ? addr_match
          : (phase == CBR_CTRL || phase == CBR_DATA); // [RL11]
      end else if (scl_fall && bit_cnt == BIT_LAST + 4'h1 && ack_armed) begin
        o_sda_oe_b <= 1'b0; // [RL12]
      end else if (scl_fall && bit_cnt == BIT_ACK + 4'h1) begin
        o_sda_oe_b <= 1'b1; // [RL12]
        ack_armed <= 1'b0;
      end
    end
  end

  // ************************************************************
  // data path to fifo
  // ************************************************************
  logic push_valid;
  logic push_ready;
  logic [ITEM_W-1:0] push_item;
  logic pop_valid;
  logic [ITEM_W-1:0] pop_item;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      push_valid <= 1'b0;
      push_item <= '0;
    end else if (byte_done && phase == CBR_DATA && dest != DEST_NONE) begin
      push_valid <= 1'b1; // [RL18]
      push_item <= {dest, next_shift};
    end else if (push_ready) begin
      push_valid <= 1'b0;
    end
  end

  cbr_fifo #(
    .WIDTH(ITEM_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_in_valid(push_valid),
    .o_in_ready(push_ready),
    .i_in_data(push_item),
    .o_out_valid(pop_valid),
    .i_out_ready(i_data_ready && !o_data_valid),
    .o_out_data(pop_item)
  );

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data_valid <= 1'b0;
      o_data <= '0;
      o_destination_select_field <= DEST_CMD;
    end else if (pop_valid && i_data_ready && !o_data_valid) begin
      o_data_valid <= 1'b1;
      o_data <= pop_item[DATA_W-1:0];
      o_destination_select_field <= pop_item[ITEM_W-1:DATA_W];
    end else begin
      o_data_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (phase != CBR_IDLE);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_start_to_addr;
    @(posedge i_clk) disable iff (!i_rst_b)
    start_cond |=> (phase == CBR_ADDR);
  endproperty
  a_start_to_addr: assert property (p_start_to_addr) else $error("start not seen"); // [RL8]

  property p_stop_to_idle;
    @(posedge i_clk) disable iff (!i_rst_b)
    stop_cond && !start_cond |=> (phase == CBR_IDLE) ##1 !o_busy ##0 (phase == CBR_IDLE || start_cond);
  endproperty
  a_stop_to_idle: assert property (p_stop_to_idle) else $error("stop not seen"); // [RL9]

  property p_addr_then_ctrl;
    @(posedge i_clk) disable iff (!i_rst_b)
    (phase == CBR_ADDR && byte_done && addr_match && !start_cond && !stop_cond) |=> (phase == CBR_CTRL);
  endproperty
  a_addr_then_ctrl: assert property (p_addr_then_ctrl) else $error("no control byte phase"); // [RL1]

  property p_mismatch_ignored;
    @(posedge i_clk) disable iff (!i_rst_b)
    (phase == CBR_IGNORE) |-> !push_valid || $past(phase) != CBR_IGNORE || $stable(push_item);
  endproperty
  a_mismatch_ignored: assert property (p_mismatch_ignored) else $error("ignored access pushed data"); // [RL17]

  property p_ctrl_fields;
    @(posedge i_clk) disable iff (!i_rst_b)
    (phase == CBR_CTRL && byte_done && !start_cond && !stop_cond)
      |=> (dest == $past(next_shift[SEL_HI:SEL_LO])) && (cont_pending == $past(next_shift[CONT_BIT]));
  endproperty
  a_ctrl_fields: assert property (p_ctrl_fields) else $error("control fields wrong"); // [RL4]

  property p_cont_back;
    @(posedge i_clk) disable iff (!i_rst_b)
    (phase == CBR_DATA && cont_pending && byte_done && !start_cond && !stop_cond) |=> (phase == CBR_CTRL);
  endproperty
  a_cont_back: assert property (p_cont_back) else $error("continuation lost"); // [RL3]

  property p_ack_low;
    @(posedge i_clk) disable iff (!i_rst_b)
    (scl_s && ack_armed && bit_cnt == BIT_ACK + 4'h1) |-> (!o_sda_oe_b && !o_sda);
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack released in high phase"); // [RL12]

  property p_ack_each;
    @(posedge i_clk) disable iff (!i_rst_b)
    (byte_done && (phase == CBR_CTRL || phase == CBR_DATA) && !start_cond && !stop_cond) |=> ack_armed;
  endproperty
  a_ack_each: assert property (p_ack_each) else $error("byte not acknowledged"); // [RL11]

  property p_data_tag;
    @(posedge i_clk) disable iff (!i_rst_b)
    (byte_done && phase == CBR_DATA && dest != DEST_NONE && !start_cond && !stop_cond)
      |=> push_valid && push_item[ITEM_W-1:DATA_W] == $past(dest);
  endproperty
  a_data_tag: assert property (p_data_tag) else $error("data tag wrong"); // [RL18]

  property p_only_ack_drives;
    @(posedge i_clk) disable iff (!i_rst_b)
    !o_sda_oe_b |-> ack_armed && (bit_cnt == BIT_ACK || bit_cnt == BIT_ACK + 4'h1);
  endproperty
  a_only_ack_drives: assert property (p_only_ack_drives) else $error("data line driven outside ack"); // [RL14]

  property p_addr_select;
    @(posedge i_clk) disable iff (!i_rst_b)
    (phase == CBR_ADDR && byte_done && !start_cond && !stop_cond && next_shift[ADDR_SEL_BIT] != sel_s)
      |=> (phase == CBR_IGNORE);
  endproperty
  a_addr_select: assert property (p_addr_select) else $error("other select level accepted"); // [RL15]

  property p_busy_after_start;
    @(posedge i_clk) disable iff (!i_rst_b)
    start_cond |-> ##2 o_busy;
  endproperty
  a_busy_after_start: assert property (p_busy_after_start) else $error("busy not raised"); // [RL8]
endmodule
`default_nettype wire

// [cbr_master_model.sv]
// two-wire bus master model for the control byte receiver
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ns
`default_nettype none
module cbr_master_model (
  input wire logic i_clk,
  input wire logic i_sda_line,
  output logic o_scl,
  output logic o_sda_drv
);
  initial begin
    o_scl = 1'b1;
    o_sda_drv = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // also serves as repeated start from a low clock
  task automatic start();
    o_sda_drv = 1'b1;
    hold(2);
    o_scl = 1'b1;
    hold(2);
    o_sda_drv = 1'b0;
    hold(2);
    o_scl = 1'b0;
    hold(2);
  endtask

  task automatic stop();
    o_sda_drv = 1'b0;
    hold(2);
    o_scl = 1'b1;
    hold(2);
    o_sda_drv = 1'b1;
    hold(4);
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      o_sda_drv = b[i];
      hold(2);
      o_scl = 1'b1;
      hold(4);
      o_scl = 1'b0;
      hold(2);
    end
    o_sda_drv = 1'b1;
    hold(2);
    o_scl = 1'b1;
    hold(1);
    ack = i_sda_line;
    hold(2);
    ack = ack | i_sda_line;
    hold(1);
    o_scl = 1'b0;
    hold(4);
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the control byte receiver
// assumes cbr_pkg, cbr_fifo, cbr_receiver and the master model
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cbr_pkg::*;
  logic i_clk, i_rst_b, data_ready, sel_pin, scl, sda_drv, sda_out, sda_oe_b, data_valid, busy;
  logic [7:0] data;
  logic [1:0] field;
  wire logic sda_line;
  int num_errors = 0;
  int comparisons = 0;
  logic [9:0] got_q[$];
  logic [9:0] exp_q[$];

  // ************
  // wiring
  // ************
  assign sda_line = sda_drv & (sda_oe_b | sda_out);

  cbr_receiver u_cbr_receiver (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda_line),
    .o_sda(sda_out), .o_sda_oe_b(sda_oe_b), .i_address_select_pin(sel_pin), .o_data_valid(data_valid),
    .i_data_ready(data_ready), .o_data(data), .o_destination_select_field(field), .o_busy(busy));
  cbr_master_model u_cbr_master_model (.i_clk(i_clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda_drv(sda_drv));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  always @(negedge i_clk) begin
    if (data_valid === 1'b1) got_q.push_back({field, data});
  end

  // ************
  // checking
  // ************
  task automatic chk_bit(input string what, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chk_item(input string what, input logic [9:0] e, input logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_out(input int wait_clks);
    repeat (wait_clks) @(negedge i_clk);
    chk_item("count", 10'(exp_q.size()), 10'(got_q.size()));
    foreach (exp_q[i]) chk_item("item", exp_q[i], (i < got_q.size()) ? got_q[i] : 10'h3FF);
    exp_q.delete();
    got_q.delete();
  endtask

  task automatic wr(input logic [7:0] b, input logic line_exp);
    logic a;
    u_cbr_master_model.put_byte(b, a);
    chk_bit("ack", line_exp, a);
  endtask

  task automatic xfer(input logic [7:0] bytes[$], input logic line_exp);
    u_cbr_master_model.start();
    foreach (bytes[i]) wr(bytes[i], line_exp);
    u_cbr_master_model.stop();
  endtask

  // ************
  // scenarios
  // ************
  task automatic t_single();
    u_cbr_master_model.start();
    chk_bit("busy", 1'b1, busy);
    wr(8'h72, 1'b0);
    wr(8'h20, 1'b0);
    wr(8'h55, 1'b0);
    u_cbr_master_model.stop();
    chk_bit("busy", 1'b0, busy);
    exp_q = '{10'h155};
    check_out(20);
  endtask

  task automatic t_mix();
    xfer('{8'h72, 8'h9F, 8'hA1, 8'hC0, 8'h3C, 8'hE0, 8'h99, 8'h60, 8'h77}, 1'b0);
    exp_q = '{10'h0A1, 10'h23C};
    check_out(20);
    xfer('{8'h72, 8'h20, 8'hC0, 8'h80}, 1'b0);
    exp_q = '{10'h1C0, 10'h180};
    check_out(20);
  endtask

  task automatic t_addr();
    xfer('{8'h70, 8'h20, 8'h55}, 1'b1);
    xfer('{8'h73, 8'h20, 8'h55}, 1'b1);
    xfer('{8'h76, 8'h20, 8'h55}, 1'b1);
    check_out(20);
    sel_pin = 1'b0;
    xfer('{8'h72, 8'h20, 8'h55}, 1'b1);
    xfer('{8'h70, 8'h20, 8'h55}, 1'b0);
    sel_pin = 1'b1;
    exp_q = '{10'h155};
    check_out(20);
  endtask

  task automatic t_restart();
    u_cbr_master_model.start();
    wr(8'h72, 1'b0);
    wr(8'h20, 1'b0);
    wr(8'h11, 1'b0);
    u_cbr_master_model.start();
    wr(8'h72, 1'b0);
    wr(8'h44, 1'b0);
    wr(8'h22, 1'b0);
    u_cbr_master_model.stop();
    exp_q = '{10'h111, 10'h222};
    check_out(20);
  endtask

  task automatic t_fifo();
    logic [7:0] bytes[$];
    data_ready = 1'b0;
    bytes = '{8'h72, 8'h00};
    for (int i = 0; i < 34; i++) bytes.push_back(8'(i));
    xfer(bytes, 1'b0);
    chk_item("stalled", 10'h000, 10'(got_q.size()));
    @(negedge i_clk);
    data_ready = 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++) exp_q.push_back({DEST_CMD, 8'(i)});
    // last byte replaces the one waiting for room
    exp_q.push_back({DEST_CMD, 8'(FIFO_DEPTH + 1)});
    check_out(120);
  endtask

  task automatic summarize();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge i_clk);
    num_errors++;
    summarize();
  end

  initial begin
    i_rst_b = 1'b0;
    data_ready = 1'b1;
    sel_pin = 1'b1;
    repeat (12) @(negedge i_clk);
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_clk);
    t_single();
    t_mix();
    t_addr();
    t_restart();
    t_fifo();
    summarize();
  end
endmodule
`default_nettype wire
